// File: ccb_backoff.sv
/*
  Clear channel assessment and transmit backoff unit.
  Assumes a transmit source that holds txReq.valid until txRes.done, and an
  energy detector that answers edStart with edDone and an energy code where
  a larger code means a weaker (more negative dBm) level.
*/
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "ccb_regs.svh"
module ccb_backoff
  import ccb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire ccb_bus_t    bus,
  output logic [15:0]      rdata,
  input  wire ccb_txreq_t  txReq,
  output ccb_txres_t       txRes,
  output logic             txGo,
  output logic             edStart,
  input  wire logic        edDone,
  input  wire logic [7:0]  edLevel
);

  // ****************************************************************
  // Types and helpers
  // ****************************************************************
  typedef enum logic [2:0] {
    IDLE, BACKOFF, DETECT, WAITED, APPDLY, DONE
  } ccb_state_t;

  // Codes are inverted dBm: energy is louder than threshold when code smaller
  function automatic logic ccb_busy(input logic [7:0] lvl,
                                    input logic [7:0] thr);
    ccb_busy = (lvl < thr);
  endfunction : ccb_busy

  // Mask of 2^n - 1 on the random draw
  function automatic logic [15:0] ccb_mask(input logic [2:0] n);
    ccb_mask = 16'((17'h00001 << n) - 17'h00001);
  endfunction : ccb_mask

  // ****************************************************************
  // Submodules
  // ****************************************************************
  logic [15:0] rnd;
  logic        symTick;

  ccb_lfsr u_lfsr (
    .clock (clock),
    .reset (reset),
    .rnd   (rnd)
  );

  ccb_symtick u_tick (
    .clock (clock),
    .reset (reset),
    .tick  (symTick)
  );

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [7:0]  thresh_ff,  nxt_thresh;
  logic [2:0]  minBe_ff,   nxt_minBe;
  logic        macMode_ff, nxt_macMode;
  logic [1:0]  retry_ff,   nxt_retry;
  logic [15:0] failCnt_ff, nxt_failCnt;
  logic [15:0] rdata_ff,   nxt_rdata;
  logic        macFail;
  ccb_state_t  state_ff;

  // Register writes, read mux and failure counting
  always_comb begin
    nxt_thresh  = thresh_ff;
    nxt_minBe   = minBe_ff;
    nxt_macMode = macMode_ff;
    nxt_retry   = retry_ff;
    nxt_failCnt = failCnt_ff;
    nxt_rdata   = 16'h0000;
    if (macFail && failCnt_ff != `CCB_FAIL_MAX) begin
      nxt_failCnt = failCnt_ff + 16'h0001;
    end
    if (bus.wr) begin
      case (bus.addr)
        `CCB_OFF_THRESH: begin
          // Clamp so a code never goes above that of the weakest allowed level
          nxt_thresh = (bus.wdata[7:0] > `CCB_THRESH_MAX) ?
                       `CCB_THRESH_MAX : bus.wdata[7:0];
        end
        `CCB_OFF_MINBE: begin
          nxt_minBe = (bus.wdata[2:0] > `CCB_BE_MAX) ?
                      `CCB_BE_MAX : bus.wdata[2:0];
        end
        `CCB_OFF_MACMODE: nxt_macMode = bus.wdata[0];
        `CCB_OFF_RETRY:   nxt_retry   = bus.wdata[1:0];
        `CCB_OFF_FAILCNT: begin
          // A zero write restarts statistics; a same-cycle failure still counts
          if (bus.wdata == 16'h0000) begin
            nxt_failCnt = macFail ? 16'h0001 : 16'h0000;
          end
        end
        default: ;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        `CCB_OFF_THRESH:  nxt_rdata = {8'h00, thresh_ff};
        `CCB_OFF_MINBE:   nxt_rdata = {13'h0000, minBe_ff};
        `CCB_OFF_MACMODE: nxt_rdata = {15'h0000, macMode_ff};
        `CCB_OFF_RETRY:   nxt_rdata = {14'h0000, retry_ff};
        `CCB_OFF_FAILCNT: nxt_rdata = failCnt_ff;
        `CCB_OFF_STATUS:  nxt_rdata = {13'h0000, state_ff};
        default:          nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      thresh_ff  <= `CCB_THRESH_RST;
      minBe_ff   <= `CCB_MINBE_RST;
      macMode_ff <= 1'b0;
      retry_ff   <= `CCB_RETRY_RST;
      failCnt_ff <= 16'h0000;
      rdata_ff   <= 16'h0000;
    end else begin
      thresh_ff  <= nxt_thresh;
      minBe_ff   <= nxt_minBe;
      macMode_ff <= nxt_macMode;
      retry_ff   <= nxt_retry;
      failCnt_ff <= nxt_failCnt;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  // ****************************************************************
  // Transmit sequence
  // ****************************************************************
  ccb_state_t  nxt_state;
  logic [2:0]  be_ff,     nxt_be;
  logic [2:0]  cycles_ff, nxt_cycles;
  logic [1:0]  appLeft_ff, nxt_appLeft;
  logic [15:0] periods_ff, nxt_periods;
  logic [4:0]  sym_ff,     nxt_sym;
  logic [19:0] dly_ff,     nxt_dly;
  logic        ok_ff,      nxt_ok;
  logic        err_ff,     nxt_err;
  logic        go_ff,      nxt_go;
  logic        busy;

  assign busy = ccb_busy(edLevel, thresh_ff);

  // Mac mode one gives no application retries; in mode zero broadcast always gets two
  function automatic logic [1:0] ccb_retries(input logic mm,
                                             input logic bc,
                                             input logic [1:0] rr);
    if (mm) ccb_retries = 2'h0;
    else if (bc || rr == 2'h0) ccb_retries = `CCB_APP_RETRIES;
    else ccb_retries = (rr > `CCB_APP_RETRIES) ? `CCB_APP_RETRIES : rr;
  endfunction : ccb_retries

  // Next-state logic of the unslotted backoff loop
  always_comb begin
    nxt_state   = state_ff;
    nxt_be      = be_ff;
    nxt_cycles  = cycles_ff;
    nxt_appLeft = appLeft_ff;
    nxt_periods = periods_ff;
    nxt_sym     = sym_ff;
    nxt_dly     = dly_ff;
    nxt_ok      = 1'b0;
    nxt_err     = 1'b0;
    nxt_go      = 1'b0;
    macFail     = 1'b0;
    case (state_ff)
      IDLE: begin
        if (txReq.valid) begin
          nxt_appLeft = ccb_retries(macMode_ff, txReq.bcast,
                                    retry_ff);
          nxt_be      = minBe_ff;
          nxt_cycles  = 3'h0;
          nxt_periods = rnd & ccb_mask(minBe_ff);
          nxt_sym     = 5'h00;
          nxt_state   = BACKOFF;
        end
      end
      BACKOFF: begin
        // Count whole backoff periods of twenty symbols
        if (periods_ff == 16'h0000) begin
          nxt_state = DETECT;
        end else if (symTick) begin
          if (sym_ff == `CCB_SYM_PER_BO - 5'h01) begin
            nxt_sym     = 5'h00;
            nxt_periods = periods_ff - 16'h0001;
          end else begin
            nxt_sym = sym_ff + 5'h01;
          end
        end
      end
      DETECT: nxt_state = WAITED;
      WAITED: begin
        if (edDone) begin
          if (!busy) begin
            nxt_go    = 1'b1;
            nxt_ok    = 1'b1;
            nxt_state = DONE;
          end else if (cycles_ff == `CCB_CYCLES_PER_TRY - 3'h1) begin
            macFail = 1'b1;
            if (appLeft_ff == 2'h0) begin
              nxt_err   = 1'b1;
              nxt_state = DONE;
            end else begin
              nxt_appLeft = appLeft_ff - 2'h1;
              // Random wait in the 1..48 ms window; 16-bit draw keeps it short
              nxt_dly = 20'(`CCB_APP_MIN_CYC) +
                        ({4'h0, rnd} % 20'(`CCB_APP_SPAN_CYC));
              nxt_state = APPDLY;
            end
          end else begin
            nxt_cycles  = cycles_ff + 3'h1;
            nxt_be      = (be_ff == `CCB_BE_MAX) ? be_ff : be_ff + 3'h1;
            nxt_periods = rnd & ccb_mask(nxt_be);
            nxt_sym     = 5'h00;
            nxt_state   = BACKOFF;
          end
        end
      end
      APPDLY: begin
        if (dly_ff == 20'h00000) begin
          nxt_be      = minBe_ff;
          nxt_cycles  = 3'h0;
          nxt_periods = rnd & ccb_mask(minBe_ff);
          nxt_sym     = 5'h00;
          nxt_state   = BACKOFF;
        end else begin
          nxt_dly = dly_ff - 20'h00001;
        end
      end
      DONE: begin
        if (!txReq.valid) nxt_state = IDLE;
      end
      default: nxt_state = IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_ff   <= IDLE;
      be_ff      <= 3'h0;
      cycles_ff  <= 3'h0;
      appLeft_ff <= 2'h0;
      periods_ff <= 16'h0000;
      sym_ff     <= 5'h00;
      dly_ff     <= 20'h00000;
      ok_ff      <= 1'b0;
      err_ff     <= 1'b0;
      go_ff      <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      be_ff      <= nxt_be;
      cycles_ff  <= nxt_cycles;
      appLeft_ff <= nxt_appLeft;
      periods_ff <= nxt_periods;
      sym_ff     <= nxt_sym;
      dly_ff     <= nxt_dly;
      ok_ff      <= nxt_ok;
      err_ff     <= nxt_err;
      go_ff      <= nxt_go;
    end
  end

  assign edStart      = (state_ff == DETECT);
  assign txGo         = go_ff;
  assign txRes.done   = ok_ff | err_ff;
  assign txRes.ok     = ok_ff;
  assign txRes.ccaErr = err_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_busy_no_go: assert property (
    @(posedge clock) disable iff (reset)
    (state_ff == WAITED && edDone && busy) |=> !txGo)
    else $error("transmit started on busy channel");

  a_clear_go: assert property (
    @(posedge clock) disable iff (reset)
    (state_ff == WAITED && edDone && !busy) |=> txGo && txRes.ok)
    else $error("clear channel did not start transmit");

  a_thresh_max: assert property (
    @(posedge clock) disable iff (reset)
    thresh_ff <= `CCB_THRESH_MAX)
    else $error("threshold beyond weakest code");

  a_fail_count: assert property (
    @(posedge clock) disable iff (reset)
    (macFail && !bus.wr && failCnt_ff != `CCB_FAIL_MAX)
      |=> failCnt_ff == $past(failCnt_ff) + 16'h0001)
    else $error("failure not counted");

  a_fail_sat: assert property (
    @(posedge clock) disable iff (reset)
    (failCnt_ff == `CCB_FAIL_MAX && !bus.wr)
      |=> failCnt_ff == `CCB_FAIL_MAX)
    else $error("failure counter wrapped");

  a_fail_clear: assert property (
    @(posedge clock) disable iff (reset)
    (bus.wr && bus.addr == `CCB_OFF_FAILCNT && bus.wdata == 16'h0000
      && !macFail) |=> failCnt_ff == 16'h0000)
    else $error("failure counter not cleared");

  a_err_end: assert property (
    @(posedge clock) disable iff (reset)
    txRes.ccaErr |-> !txGo ##1 (state_ff == DONE || state_ff == IDLE))
    else $error("error without ending frame");

  a_zero_be: assert property (
    @(posedge clock) disable iff (reset)
    (state_ff == IDLE && txReq.valid && minBe_ff == 3'h0)
      |=> ##1 edStart)
    else $error("delay inserted with zero exponent");

  // Error only follows the last MAC failure, with no retry left
  a_err_after_fail: assert property (
    @(posedge clock) disable iff (reset)
    txRes.ccaErr |-> $past(macFail) && $past(appLeft_ff) == 2'h0)
    else $error("error reported with retries left");

  // In mac mode zero, broadcast, or unicast with zero retry count, loads two retries
  a_bcast_retry: assert property (
    @(posedge clock) disable iff (reset)
    (state_ff == IDLE && txReq.valid && !macMode_ff
      && (txReq.bcast || retry_ff == 2'h0))
      |=> appLeft_ff == `CCB_APP_RETRIES)
    else $error("two retries not granted");

  // Every frame restarts from the minimum exponent
  a_be_start: assert property (
    @(posedge clock) disable iff (reset)
    (state_ff == IDLE && txReq.valid)
      |=> be_ff == $past(minBe_ff) && cycles_ff == 3'h0)
    else $error("frame did not start at minimum exponent");

endmodule : ccb_backoff

// File: ccb_regs.svh
/*
  Register offsets, reset values and timing constants of the clear channel
  backoff unit. Assumes a 20 MHz system clock.
*/
`ifndef CCB_REGS_SVH
`define CCB_REGS_SVH

// ****************************************************************
// Register map (word offsets on the plain register port)
// ****************************************************************
`define CCB_OFF_THRESH     4'h0
`define CCB_OFF_MINBE      4'h1
`define CCB_OFF_MACMODE    4'h2
`define CCB_OFF_RETRY      4'h3
`define CCB_OFF_FAILCNT    4'h4
`define CCB_OFF_STATUS     4'h5

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define CCB_THRESH_RST     8'h2C
`define CCB_THRESH_MAX     8'h50
`define CCB_MINBE_RST      3'h0
`define CCB_BE_MAX         3'h5
`define CCB_FAIL_MAX       16'hFFFF
`define CCB_CYCLES_PER_TRY 3'h5
`define CCB_APP_RETRIES    2'h2
`define CCB_RETRY_RST      2'h3
`define CCB_LFSR_SEED      16'hACE1
`define CCB_LFSR_TAPS      16'hB400

// ****************************************************************
// Timing
// ****************************************************************
`define CCB_CLK_HZ         20000000
`define CCB_SYM_HZ         62500
`define CCB_SYM_CYC        (`CCB_CLK_HZ / `CCB_SYM_HZ)
`define CCB_SYM_PER_BO     5'h14
`define CCB_APP_DLY_MIN_MS 1
`define CCB_APP_DLY_MAX_MS 48
`define CCB_CYC_PER_MS     (`CCB_CLK_HZ / 1000)
`define CCB_APP_MIN_CYC    (`CCB_APP_DLY_MIN_MS * `CCB_CYC_PER_MS)
`define CCB_APP_SPAN_MS    (`CCB_APP_DLY_MAX_MS - `CCB_APP_DLY_MIN_MS)
`define CCB_APP_SPAN_CYC   (`CCB_APP_SPAN_MS * `CCB_CYC_PER_MS)

`endif

// File: ccb_pkg.sv
/*
  Types shared by the clear channel backoff unit.
  Assumes ccb_regs.svh holds the numeric constants.
*/
package ccb_pkg;

  // Software register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ccb_bus_t;

  // Transmit request from the source
  typedef struct packed {
    logic valid;
    logic bcast;
  } ccb_txreq_t;

  // Result reported back for one frame
  typedef struct packed {
    logic done;
    logic ok;
    logic ccaErr;
  } ccb_txres_t;

endpackage : ccb_pkg

// File: ccb_lfsr.sv
/*
  Free running 16-bit pseudo random source for the backoff draws.
  Assumes a single clock and an asynchronous active high reset.
*/
`timescale 1ns/1ps
`include "ccb_regs.svh"
module ccb_lfsr
  import ccb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  output logic [15:0]      rnd
);

  logic [15:0] lfsr_ff;
  logic [15:0] nxt_lfsr;

  // Galois taps 16,14,13,11 give a maximal sequence; seed must be nonzero
  always_comb begin
    nxt_lfsr = {1'b0, lfsr_ff[15:1]};
    if (lfsr_ff[0]) begin
      nxt_lfsr = nxt_lfsr ^ `CCB_LFSR_TAPS;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lfsr_ff <= `CCB_LFSR_SEED;
    end else begin
      lfsr_ff <= nxt_lfsr;
    end
  end

  assign rnd = lfsr_ff;

endmodule : ccb_lfsr

// File: ccb_symtick.sv
/*
  Symbol rate tick generator: one pulse per radio symbol time.
  Assumes a 20 MHz clock; ratio comes from ccb_regs.svh.
*/
`timescale 1ns/1ps
`include "ccb_regs.svh"
module ccb_symtick
  import ccb_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  output logic      tick
);

  logic [9:0] cnt_ff;
  logic [9:0] nxt_cnt;
  logic       tick_ff;
  logic       nxt_tick;

  // Divide the system clock down to the symbol rate
  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt  = cnt_ff + 10'h001;
    if (cnt_ff == 10'(`CCB_SYM_CYC - 1)) begin
      nxt_cnt  = 10'h000;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_ff  <= 10'h000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : ccb_symtick

// File: ccb_radio_model.sv
/*
  Behavioural energy detector at the far side of the backoff unit.
  Assumes edStart is a one-cycle pulse and the same clock as the unit.
*/
`timescale 1ns/1ps
module ccb_radio_model
  import ccb_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       edStart,
  input  wire logic       arm,
  input  wire logic [7:0] busyN,
  input  wire logic [7:0] busyLvl,
  input  wire logic [7:0] clearLvl,
  input  wire logic [2:0] lat,
  output logic            edDone,
  output logic [7:0]      edLevel
);
  int cnt_ff;
  int wait_ff;

  // ****************************************************************
  // Detection answer
  // ****************************************************************
  // First busyN answers of a frame are busy; the level toggles outside
  // the result cycle so a late sample never looks valid
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_ff <= 0;
      wait_ff <= -1;
      edDone <= 1'b0;
      edLevel <= 8'hA5;
    end else begin
      edDone <= 1'b0;
      edLevel <= ~edLevel;
      if (arm) begin
        cnt_ff <= 0;
      end
      if (edStart) begin
        wait_ff <= int'(lat);
      end else if (wait_ff > 0) begin
        wait_ff <= wait_ff - 1;
      end else if (wait_ff == 0) begin
        wait_ff <= -1;
        edDone <= 1'b1;
        edLevel <= (cnt_ff < int'(busyN)) ? busyLvl : clearLvl;
        cnt_ff <= cnt_ff + 1;
      end
    end
  end
endmodule : ccb_radio_model

// File: tb_clear_channel_backoff.sv
/*
  Self-checking bench of the clear channel backoff unit.
  Assumes a 20 MHz clock and the detector model in ccb_radio_model.
*/
`timescale 1ns/1ps
`include "ccb_regs.svh"
module tb_clear_channel_backoff
  import ccb_pkg::*;
;
  localparam int BO = 6400; // Cycles in one backoff period
  localparam int SL = 400;  // Slack for detector latency and tick phase
  logic       clock = 1'b0;
  logic       reset;
  ccb_bus_t   bus;
  logic [15:0] rdata;
  ccb_txreq_t txReq;
  ccb_txres_t txRes;
  logic       txGo;
  logic       edStart;
  logic       edDone;
  logic [7:0] edLevel;
  logic       arm;
  logic [7:0] busyN;
  logic [7:0] busyLvl;
  logic [7:0] clearLvl;
  logic [2:0] lat;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         mFail;
  logic [7:0] mThr;
  logic [15:0] d;
  logic       okv;
  logic       errv;
  logic       gov;
  time        stQ[$];
  time        tReq;

  always #25 clock = ~clock;

  // Start times of every energy detection
  always @(posedge clock) begin
    if (edStart === 1'b1) begin
      stQ.push_back($time);
    end
  end

  ccb_backoff ccb_backoff_i (.clock(clock), .reset(reset), .bus(bus),
    .rdata(rdata), .txReq(txReq), .txRes(txRes), .txGo(txGo),
    .edStart(edStart), .edDone(edDone), .edLevel(edLevel));
  ccb_radio_model ccb_radio_model_i (.clock(clock), .reset(reset),
    .edStart(edStart), .arm(arm), .busyN(busyN), .busyLvl(busyLvl),
    .clearLvl(clearLvl), .lat(lat), .edDone(edDone), .edLevel(edLevel));

  // ****************************************************************
  // Bus, frame and compare tasks
  // ****************************************************************
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge clock);
    bus <= '{a, w, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] r);
    @(posedge clock);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 r = rdata;
  endtask : reg_rd

  // Holds the request until done, as the source must
  task automatic send(input logic bc);
    int k;
    @(posedge clock);
    txReq <= '{1'b1, bc};
    arm <= 1'b1;
    stQ.delete();
    tReq = $time;
    k = 0;
    do begin
      @(posedge clock);
      arm <= 1'b0;
      #1 k++;
    end while (txRes.done !== 1'b1 && k < 300000);
    okv = txRes.ok;
    errv = txRes.ccaErr;
    gov = txGo;
    @(posedge clock);
    txReq <= '0;
  endtask : send

  task automatic miss(input string m);
    n_mismatch++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : miss

  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) miss($sformatf("reg %h exp %h", g, e));
  endtask : chk_reg

  task automatic chk_tx(input logic e);
    n_tests++;
    if (okv !== e || gov !== e || errv !== !e) miss("frame result");
  endtask : chk_tx

  task automatic chk_gap(input time g, input int lim);
    n_tests++;
    if (g / 50 > lim) miss($sformatf("gap %0d cycles over %0d", g / 50, lim));
  endtask : chk_gap

  task automatic complete_run;
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (300000) @(posedge clock);
    miss("watchdog expired");
    complete_run();
  end

  initial begin
    reset = 1'b1;
    bus = '0;
    txReq = '0;
    arm = 1'b0;
    busyN = 8'h00;
    busyLvl = 8'h10;
    clearLvl = 8'h60;
    lat = 3'h1;
    mFail = 0;
    void'($urandom(77));
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    reg_rd(`CCB_OFF_THRESH, d); chk_reg(d, 16'h002C);
    reg_rd(`CCB_OFF_MINBE, d); chk_reg(d, 16'h0000);
    reg_rd(`CCB_OFF_MACMODE, d); chk_reg(d, 16'h0000);
    reg_rd(`CCB_OFF_RETRY, d); chk_reg(d, 16'h0003);
    reg_rd(`CCB_OFF_FAILCNT, d); chk_reg(d, 16'h0000);
    reg_rd(4'hF, d); chk_reg(d, 16'h0000);
    reg_wr(`CCB_OFF_THRESH, 16'h0050);
    reg_rd(`CCB_OFF_THRESH, d); chk_reg(d, 16'h0050);
    reg_wr(`CCB_OFF_THRESH, 16'h0060);
    reg_rd(`CCB_OFF_THRESH, d); chk_reg(d, 16'h0050);
    $display("test registers done");
    // Level equal to the code is not above the threshold, so it is clear
    for (int i = 0; i < 6; i++) begin
      mThr = 8'(8'h20 + $urandom % 49);
      reg_wr(`CCB_OFF_THRESH, {8'h00, mThr});
      clearLvl <= (i == 0) ? mThr : 8'(mThr + $urandom % (256 - mThr));
      lat <= 3'($urandom % 5);
      // First frame is broadcast so the two-retry grant is always seen
      send((i == 0) ? 1'b1 : 1'($urandom % 2));
      chk_tx(1'b1);
      chk_gap(stQ[0] - tReq, 5);
    end
    $display("test clear_frames done");
    // One code below the threshold is busy, then one backoff at most
    busyLvl <= mThr - 8'h01;
    busyN <= 8'h01;
    send(1'b0);
    chk_tx(1'b1);
    chk_gap(stQ[1] - stQ[0], BO + SL);
    reg_rd(`CCB_OFF_FAILCNT, d); chk_reg(d, 16'(mFail));
    reg_wr(`CCB_OFF_MINBE, 16'h0002);
    busyN <= 8'h00;
    send(1'b0);
    chk_gap(stQ[0] - tReq, 3 * BO + SL);
    reg_wr(`CCB_OFF_MINBE, 16'h0000);
    $display("test single_busy done");
    // Mode one has no application retry, so five busy checks end it
    reg_wr(`CCB_OFF_MACMODE, 16'h0001);
    busyN <= 8'h05;
    send(1'b0);
    chk_tx(1'b0);
    chk_reg(16'(stQ.size()), 16'h0005);
    for (int k = 1; k < 5 && k < stQ.size(); k++) begin
      chk_gap(stQ[k] - stQ[k - 1], ((1 << k) - 1) * BO + SL);
    end
    mFail++;
    reg_rd(`CCB_OFF_FAILCNT, d); chk_reg(d, 16'(mFail));
    $display("test cca_error done");
    reg_wr(`CCB_OFF_FAILCNT, 16'h1234);
    reg_rd(`CCB_OFF_FAILCNT, d); chk_reg(d, 16'(mFail));
    reg_wr(`CCB_OFF_FAILCNT, 16'h0000);
    mFail = 0;
    reg_rd(`CCB_OFF_FAILCNT, d); chk_reg(d, 16'(mFail));
    $display("test fail_clear done");
    complete_run();
  end
endmodule : tb_clear_channel_backoff
